// ### design/ec_addr_defs.vh
// Purpose: constants for the embedded controller address space decoder
// Assumes: 32-bit virtual and physical addresses
// Notes:   region bounds are physical byte addresses
`ifndef EC_ADDR_DEFS_VH
`define EC_ADDR_DEFS_VH

`define NEAR_IRQ_VBASE   32'hbfffc000
`define NEAR_IRQ_PBASE   32'h1fffc000
`define NEAR_IRQ_PEND    32'h1fffffff
`define DATA_RAM_VBASE   32'hbfd18000
`define DATA_RAM_PBASE   32'h1fd18000
`define DATA_RAM_PEND    32'h1fd1ffff
`define CODE_RAM_PEND    32'h1fd17fff
`define CODE_RAM_96K     32'h1fd00000
`define CODE_RAM_128K    32'h1fcf8000
`define CODE_RAM_160K    32'h1fcf0000
`define CODE_VIRT_OFFSET 32'ha0000000
`define BOOT_ROM_VBASE   32'hbfc00000
`define BOOT_ROM_PBASE   32'h1fc00000
`define BOOT_ROM_PEND    32'h1fc0ffff
`define PERIPH_VBASE     32'ha0000000
`define PERIPH_PBASE     32'h00000000
`define PERIPH_PEND      32'h001fffff
`define DEBUG_RAM_PBASE  32'h1fe00000
`define DEBUG_RAM_PEND   32'h1fe00fff
`define KSEG1_TOP        3'h5
`define DRAM_SPLIT_32K   2'h0
`define DRAM_SPLIT_16K   2'h1
`define DRAM_SPLIT_8K    2'h2
`define DRAM_BASE_16K    32'h1fd1c000
`define DRAM_BASE_8K     32'h1fd1e000
`define CODE_SIZE_96K    2'h0
`define CODE_SIZE_128K   2'h1
`define CODE_SIZE_160K   2'h2
`define TGT_NONE         3'h0
`define TGT_CODE         3'h1
`define TGT_DATA         3'h2
`define TGT_BOOT         3'h3
`define TGT_NEAR_IRQ     3'h4
`define TGT_PERIPH       3'h5
`define TGT_DEBUG        3'h6
`define GPR_COUNT        32
`define GPR_WIDTH        32
`define MUL_SLICE        16
`define IPL_WIDTH        6
`define VEC_WIDTH        18

`endif

// ### design/ec_address_space_decoder.v
// Purpose: decode core virtual addresses, route fetch and data ports to SRAM banks
// Assumes: one clock, synchronous active-high reset, vector/wake from outside controller
// Notes:   fetch wins collisions on the same bank; the data port stalls one cycle
`timescale 1ns/10ps
`include "ec_addr_defs.vh"

// Summary of operation
// - thirty-two 32-bit general registers, no shadows
// - multiply unit uses 32x16 array steps
// - interrupts taken from external controller
// - fixed mapping, no translation buffer
// - core virtual, dma masters present physical
// - near interrupt registers, 16 kB window
// - data RAM 32 kB at top
// - code RAM ends where the data split starts (0x1fd17fff at 32 kB), size selectable
// - boot ROM 64 kB mapping
// - peripheral registers 2 MB mapping
// - undefined address raises memory exception
// - fetch reaches code, data, boot, debug memory
// - data via data port or system bus
// - code and data in parallel, no contention
// - same-bank requests are serialized
// - data RAM split 32/16/8 kB, rest code
// - vector of highest pending priority presented
// - wake events forwarded without clock
// - first fetch after reset at boot ROM
module ec_address_space_decoder (
  // clock and reset
  input  wire        mclk_in,
  input  wire        srst_in,
  // configuration straps
  input  wire [1:0]  code_size_sel_in,
  input  wire [1:0]  dram_split_sel_in,
  // fetch port from core (virtual)
  input  wire        fetch_req_in,
  input  wire [31:0] fetch_vaddr_in,
  output reg         fetch_grant_out,
  output reg         fetch_stall_out,
  output reg         fetch_fault_out,
  output reg  [2:0]  fetch_target_out,
  output reg  [31:0] fetch_paddr_out,
  // data port from core (virtual)
  input  wire        data_req_in,
  input  wire [31:0] data_vaddr_in,
  output reg         data_grant_out,
  output reg         data_stall_out,
  output reg         data_fault_out,
  output reg  [2:0]  data_target_out,
  output reg  [31:0] data_paddr_out,
  output reg         data_sysbus_out,
  // physical-address master (dma)
  input  wire        dma_req_in,
  input  wire [31:0] dma_paddr_in,
  output reg  [2:0]  dma_target_out,
  output reg         dma_fault_out,
  // external interrupt controller
  input  wire        irq_req_in,
  input  wire [5:0]  irq_level_in,
  input  wire [17:0] irq_vector_in,
  input  wire        wake_async_in,
  output reg         core_irq_out,
  output reg  [5:0]  core_level_out,
  output reg  [17:0] core_vector_out,
  output wire        clk_wake_out,
  // reset fetch start
  output reg  [31:0] reset_fetch_addr_out
);

  reg  [1:0]  code_sel_r;
  reg  [1:0]  split_sel_r;
  reg  [1:0]  irq_sync_r;
  reg  [1:0]  code_meta_r;
  reg  [1:0]  code_sync_r;
  reg  [1:0]  split_meta_r;
  reg  [1:0]  split_sync_r;
  reg         data_wait_r;
  reg  [31:0] code_base;
  reg  [31:0] data_base;
  wire [31:0] f_paddr;
  wire [31:0] d_paddr;
  wire [2:0]  f_tgt;
  wire [2:0]  d_tgt;
  wire [2:0]  m_tgt;
  wire        f_bank;
  wire        d_bank;
  wire        clash;
  wire        f_held;
  wire        f_ok;
  wire        f_bad;
  wire [95:0] dec_addr;
  wire [8:0]  dec_tgt;

  // fixed core configuration, kept as named constants; no logic depends on them
  localparam GPRS  = `GPR_COUNT;
  localparam GPRW  = `GPR_WIDTH;
  localparam MULW  = `MUL_SLICE;

  // constant rule, no translation buffer
  function [31:0] v2p;
    input [31:0] va;
    begin
      if (va[31:29] == `KSEG1_TOP)
        v2p = {3'h0, va[28:0]};
      else
        v2p = 32'hffffffff;
    end
  endfunction

  // one decoder per master (0 fetch, 1 data, 2 dma); first match wins,
  // so the near window and the data bank are tested before the code range
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_dec
      wire [31:0] pa;
      wire        in_near;
      wire        in_data;
      wire        in_code;
      wire        in_boot;
      wire        in_periph;
      wire        in_debug;
      assign pa        = dec_addr[gi*32 +: 32];
      assign in_near   = (pa >= `NEAR_IRQ_PBASE) && (pa <= `NEAR_IRQ_PEND);
      assign in_data   = (pa >= data_base) && (pa <= `DATA_RAM_PEND);
      // code grows up to wherever the data split starts
      assign in_code   = (pa >= code_base) && (pa < data_base);
      assign in_boot   = (pa >= `BOOT_ROM_PBASE) && (pa <= `BOOT_ROM_PEND);
      assign in_periph = (pa <= `PERIPH_PEND);
      assign in_debug  = (pa >= `DEBUG_RAM_PBASE) && (pa <= `DEBUG_RAM_PEND);
      assign dec_tgt[gi*3 +: 3] = in_near   ? `TGT_NEAR_IRQ :
                                  in_data   ? `TGT_DATA     :
                                  in_code   ? `TGT_CODE     :
                                  in_boot   ? `TGT_BOOT     :
                                  in_periph ? `TGT_PERIPH   :
                                  in_debug  ? `TGT_DEBUG    :
                                              `TGT_NONE;
    end
  endgenerate

  // straps come from pins, so two flops stand before anything reads them
  always @(posedge mclk_in) begin
    code_meta_r  <= code_size_sel_in;
    code_sync_r  <= code_meta_r;
    split_meta_r <= dram_split_sel_in;
    split_sync_r <= split_meta_r;
  end

  // size straps are sampled at reset; changing them live would move banks under code
  always @(posedge mclk_in) begin
    if (srst_in) begin
      code_sel_r  <= code_sync_r;
      split_sel_r <= split_sync_r;
    end
  end

  always @* begin
    case (code_sel_r)
      `CODE_SIZE_128K: code_base = `CODE_RAM_128K;
      `CODE_SIZE_160K: code_base = `CODE_RAM_160K;
      default:         code_base = `CODE_RAM_96K;
    endcase
    case (split_sel_r)
      `DRAM_SPLIT_16K: data_base = `DRAM_BASE_16K;
      `DRAM_SPLIT_8K:  data_base = `DRAM_BASE_8K;
      default:         data_base = `DATA_RAM_PBASE;
    endcase
  end

  assign f_paddr = v2p(fetch_vaddr_in);
  assign d_paddr = v2p(data_vaddr_in);
  assign dec_addr = {dma_paddr_in, d_paddr, f_paddr};
  assign f_tgt   = dec_tgt[2:0];
  assign d_tgt   = dec_tgt[5:3];
  assign m_tgt   = dec_tgt[8:6];
  assign f_bank  = (f_tgt == `TGT_CODE) || (f_tgt == `TGT_DATA);
  assign d_bank  = (d_tgt == `TGT_CODE) || (d_tgt == `TGT_DATA);
  // different banks proceed together; same bank serializes
  assign clash   = fetch_req_in && data_req_in && f_bank && d_bank
                   && (f_tgt == d_tgt) && !data_wait_r;
  // fetch waits only while the held data access owns the very same bank
  assign f_held  = data_wait_r && f_bank && (f_tgt == data_target_out);
  // instruction memory: code, data, boot and debug banks
  assign f_ok    = (f_tgt == `TGT_CODE) || (f_tgt == `TGT_DATA)
                   || (f_tgt == `TGT_BOOT) || (f_tgt == `TGT_DEBUG);
  assign f_bad   = !f_ok;

  // fetch port results, one edge after the request
  always @(posedge mclk_in) begin
    if (srst_in) begin
      fetch_grant_out  <= 1'b0;
      fetch_stall_out  <= 1'b0;
      fetch_fault_out  <= 1'b0;
      fetch_target_out <= `TGT_NONE;
      fetch_paddr_out  <= 32'h00000000;
    end else begin
      fetch_paddr_out  <= f_paddr;
      fetch_target_out <= f_tgt;
      // fetch wins a fresh clash; it yields only the cycle after one
      fetch_grant_out  <= fetch_req_in && !f_held && f_ok;
      fetch_stall_out  <= fetch_req_in && f_held;
      // peripheral and near interrupt space are not instruction memory
      fetch_fault_out  <= fetch_req_in && f_bad;
    end
  end

  // data port: sram banks on the near port, other decoded targets on the system bus, undefined ones fault
  always @(posedge mclk_in) begin
    if (srst_in) begin
      data_grant_out  <= 1'b0;
      data_stall_out  <= 1'b0;
      data_fault_out  <= 1'b0;
      data_target_out <= `TGT_NONE;
      data_paddr_out  <= 32'h00000000;
      data_sysbus_out <= 1'b0;
      data_wait_r     <= 1'b0;
    end else begin
      data_paddr_out  <= d_paddr;
      data_target_out <= d_tgt;
      data_grant_out  <= data_req_in && !clash && d_tgt != `TGT_NONE;
      data_stall_out  <= clash;
      // the stalled access owns the bank next cycle, so data never starves
      data_wait_r     <= clash;
      data_sysbus_out <= data_req_in && !d_bank && d_tgt != `TGT_NONE;
      data_fault_out  <= data_req_in && d_tgt == `TGT_NONE;
    end
  end

  // physical masters bypass translation entirely
  always @(posedge mclk_in) begin
    if (srst_in) begin
      dma_target_out <= `TGT_NONE;
      dma_fault_out  <= 1'b0;
    end else begin
      dma_target_out <= m_tgt;
      dma_fault_out  <= dma_req_in && m_tgt == `TGT_NONE;
    end
  end

  // boot vector is a constant; the register keeps the output on a flop
  always @(posedge mclk_in) begin
    reset_fetch_addr_out <= `BOOT_ROM_PBASE;
  end

  // the outside controller chooses the highest pending vector; cross it in
  always @(posedge mclk_in) begin
    if (srst_in) begin
      irq_sync_r      <= 2'h0;
      core_irq_out    <= 1'b0;
      core_level_out  <= 6'h00;
      core_vector_out <= 18'h00000;
    end else begin
      irq_sync_r      <= {irq_sync_r[0], irq_req_in};
      core_irq_out    <= irq_sync_r[1];
      // vector and level are sampled once the request has settled
      if (irq_sync_r[1]) begin
        core_level_out  <= irq_level_in;
        core_vector_out <= irq_vector_in;
      end
    end
  end

  // wake path must work with the clock stopped, so it is combinational only
  assign clk_wake_out = wake_async_in;

endmodule // ec_address_space_decoder

// ### bench/ec_decoder_checker_asserts.sv
// Purpose: assertions on the address space decoder ports
// Assumes: one clock, synchronous active-high reset
// Notes:   results are judged one edge after the request
`timescale 1ns/10ps
module ec_decoder_checker (
  input wire        mclk_in, srst_in, fetch_req_in, data_req_in, dma_req_in, wake_async_in,
  input wire        fetch_grant_out, data_grant_out, data_stall_out, data_fault_out,
  input wire        data_sysbus_out, clk_wake_out, fetch_stall_out,
  input wire [2:0]  fetch_target_out, data_target_out, dma_target_out,
  input wire [31:0] fetch_vaddr_in, data_vaddr_in, dma_paddr_in, fetch_paddr_out,
  input wire [31:0] reset_fetch_addr_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  boot_start_a: assert property (reset_fetch_addr_out == 32'h1fc00000)
    else $error("boot start");
  kseg_map_a: assert property (fetch_req_in && fetch_vaddr_in[31:29] == 3'h5 |=>
    fetch_paddr_out == ($past(fetch_vaddr_in) & 32'h1fffffff)) else $error("kseg map");
  undef_fault_a: assert property (data_req_in && data_vaddr_in[31:29] != 3'h5 |=>
    data_fault_out) else $error("undef fault");
  periph_route_a: assert property (data_req_in && data_vaddr_in[31:21] == 11'h500 |=>
    data_target_out == 3'h5 && data_sysbus_out) else $error("periph route");
  near_dma_a: assert property (dma_req_in && dma_paddr_in[31:14] == 18'h07fff |=>
    dma_target_out == 3'h4) else $error("near dma");
  stall_turn_a: assert property (data_stall_out |-> fetch_grant_out && !data_grant_out
    ##1 data_grant_out) else $error("stall turn");
  same_bank_a: assert property (fetch_grant_out && data_grant_out &&
    fetch_target_out inside {3'h1, 3'h2} |-> data_target_out != fetch_target_out)
    else $error("same bank");
  wake_pass_a: assert property (clk_wake_out == wake_async_in) else $error("wake");
  stall_yield_a: assert property (fetch_stall_out |-> !fetch_grant_out && data_grant_out)
    else $error("stall yield");
endmodule // ec_decoder_checker
bind ec_address_space_decoder ec_decoder_checker chk (.*);

// ### bench/ec_core_model.sv
// Purpose: core model driving the fetch and data request ports
// Assumes: each offer is taken once and held while its port stalls
// Notes:   idle address lines toggle so a stale address never looks valid
`timescale 1ns/10ps
module ec_core_model (
  // offers from the bench
  input  wire        mclk_in, go_in, fv_in, dv_in,
  input  wire [31:0] fva_in, dva_in,
  // stalls from the decoder
  input  wire        fetch_stall_out, data_stall_out,
  // request ports
  output reg         fetch_req_in = 1'b0, data_req_in = 1'b0,
  output reg  [31:0] fetch_vaddr_in = 32'h0, data_vaddr_in = 32'h0
);
  always @(posedge mclk_in) begin
    #1;
    if (!fetch_stall_out) fetch_req_in = go_in && fv_in;
    if (!data_stall_out) data_req_in = go_in && dv_in;
    fetch_vaddr_in = fetch_stall_out ? fetch_vaddr_in : fetch_req_in ? fva_in : ~fetch_vaddr_in;
    data_vaddr_in = data_stall_out ? data_vaddr_in : data_req_in ? dva_in : ~data_vaddr_in;
  end
endmodule // ec_core_model

// ### bench/ec_address_space_decoder_tb.sv
// Purpose: self-checking bench for the address space decoder
// Assumes: straps settle during reset, each strap setting gets its own reset
// Notes:   a monitor pops expected results per port in request order
`timescale 1ns/10ps
module ec_address_space_decoder_tb;
  reg         mclk_in = 1'b0, srst_in = 1'b1, go_in = 1'b0, fv_in = 1'b0, dv_in = 1'b0;
  reg         dma_req_in = 1'b0, irq_req_in = 1'b0, wake_async_in = 1'b0;
  reg  [1:0]  code_size_sel_in = 2'h0, dram_split_sel_in = 2'h0;
  reg  [31:0] fva_in = 32'h0, dva_in = 32'h0, dma_paddr_in = 32'h0, lf = 32'h6b3c;
  reg  [5:0]  irq_level_in = 6'h0;
  reg  [17:0] irq_vector_in = 18'h0;
  wire        fetch_req_in, data_req_in, fetch_grant_out, fetch_stall_out, fetch_fault_out;
  wire        data_grant_out, data_stall_out, data_fault_out, data_sysbus_out, dma_fault_out;
  wire        core_irq_out, clk_wake_out;
  wire [2:0]  fetch_target_out, data_target_out, dma_target_out;
  wire [31:0] fetch_vaddr_in, data_vaddr_in, fetch_paddr_out, data_paddr_out;
  wire [31:0] reset_fetch_addr_out;
  wire [5:0]  core_level_out;
  wire [17:0] core_vector_out;
  wire [255:0] bases = {32'h9fc00000, 32'hbfffc000, 32'hbfe00000, 32'hbfd1e000,
                        32'hbfd18000, 32'hbfd00000, 32'hbfc00000, 32'ha0000000};
  reg  [36:0] fq[$], dq[$];
  integer     err_count = 0, num_checks = 0, i, cs;
  ec_address_space_decoder DUT (.*);
  ec_core_model core (.*);
  always #10 mclk_in = ~mclk_in;
  function [31:0] nxt(input [31:0] v);
    nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function [36:0] ex(input [31:0] va, input f);
    reg [31:0] pa, cb, db;
    reg [2:0]  t;
    begin
      pa = (va[31:29] == 3'h5) ? (va & 32'h1fffffff) : 32'hffffffff;
      cb = code_size_sel_in[0] ? 32'h1fcf8000 : code_size_sel_in[1] ? 32'h1fcf0000 : 32'h1fd00000;
      db = dram_split_sel_in[0] ? 32'h1fd1c000 : dram_split_sel_in[1] ? 32'h1fd1e000 : 32'h1fd18000;
      t = (pa <= 32'h001fffff) ? 3'h5 : (pa[31:16] == 16'h1fc0) ? 3'h3 :
          (pa >= cb && pa < db) ? 3'h1 : (pa >= db && pa <= 32'h1fd1ffff) ? 3'h2 :
          (pa[31:12] == 20'h1fe00) ? 3'h6 : (pa[31:14] == 18'h07fff) ? 3'h4 : 3'h0;
      ex = {!f && t >= 3'h3, t == 3'h0 || (f && t >= 3'h4 && t != 3'h6), t, pa};
    end
  endfunction
  task cmp(input [39:0] n, input [36:0] e, input [36:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("ERROR %0s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task conclude;
    begin
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  // dma mirrors the data address physically so both masters see one map
  task step(input f, input [31:0] a, input d, input [31:0] b, input [1:0] gap);
    reg [36:0] e;
    begin
      e = ex({3'h5, b[28:0]}, 1'b0);
      @(posedge mclk_in);
      {go_in, fv_in, dv_in, fva_in, dva_in} <= {1'b1, f, d, a, b};
      if (f) fq.push_back(ex(a, 1'b1));
      if (d) dq.push_back(ex(b, 1'b0));
      #1 {dma_req_in, dma_paddr_in} = {d, b & 32'h1fffffff};
      @(posedge mclk_in);
      go_in <= 1'b0;
      #1 {dma_req_in, dma_paddr_in} = {1'b0, ~dma_paddr_in};
      #1 cmp("dma", {33'h0, d && e[34:32] == 3'h0, e[34:32]}, {33'h0, dma_fault_out, dma_target_out});
      repeat (gap) @(posedge mclk_in);
    end
  endtask
  always @(posedge mclk_in) begin
    #2;
    if (fetch_grant_out || fetch_fault_out)
      cmp("fetch", fq.pop_front(), {1'b0, fetch_fault_out, fetch_target_out, fetch_paddr_out});
    if (data_grant_out || data_fault_out)
      cmp("data", dq.pop_front(), {data_sysbus_out, data_fault_out, data_target_out, data_paddr_out});
  end
  initial begin
    for (cs = 0; cs < 3; cs = cs + 1) begin
      @(posedge mclk_in);
      #1 {srst_in, code_size_sel_in, dram_split_sel_in} = {1'b1, cs[1:0], cs[1:0]};
      repeat (12) @(posedge mclk_in);
      #1 srst_in = 1'b0;
      cmp("rst", {5'h0, 32'h1fc00000}, {1'b0, fetch_grant_out, fetch_target_out, reset_fetch_addr_out});
      step(1'b1, 32'hbfc00000, 1'b0, 32'h0, 2'h1);
      step(1'b1, 32'hbfd00000, 1'b1, 32'hbfd00100, 2'h0);
      step(1'b1, 32'hbfd1f000, 1'b1, 32'hbfd1f004, 2'h0);
      step(1'b1, 32'hbfd00010, 1'b1, 32'hbfd1f010, 2'h0);
      step(1'b1, 32'hbfffc000, 1'b1, 32'ha0001000, 2'h0);
      step(1'b1, 32'hbfcfffff, 1'b1, 32'hbfd18000, 2'h0);
      step(1'b1, 32'hbfcf7fff, 1'b1, 32'hbfd1c000, 2'h0);
      for (i = 0; i < 30; i = i + 1) begin
        lf = nxt(lf);
        step(lf[31], bases[lf[2:0]*32 +: 32] + {19'h0, lf[20:8]}, lf[30],
             bases[lf[5:3]*32 +: 32] + {19'h0, lf[29:17]}, lf[7:6]);
      end
      #1 {irq_level_in, irq_vector_in, irq_req_in, wake_async_in} = {lf[5:0], lf[29:12], 2'h3};
      #1 cmp("wake", 37'h1, {36'h0, clk_wake_out});
      repeat (5) @(posedge mclk_in);
      #1 {irq_req_in, wake_async_in} = 2'h0;
      cmp("irq", {13'h1, lf[5:0], lf[29:12]}, {12'h0, core_irq_out, core_level_out, core_vector_out});
    end
    conclude;
  end
  initial begin
    #200000;
    err_count = err_count + 1;
    conclude;
  end
endmodule // ec_address_space_decoder_tb
